// ---- include/charger_regs_pkg.sv ----
// Constants, field layouts and carrier types of the charger register bank
//
// Contract
// RQ1 - Status word is meaningful only while AC or USB input power is present
// RQ2 - Two-bit scale gives 0.25, 0.5, 0.75 or full programmed current
// RQ3 - State code: 00 fault/off/suspend, 01 done, 10 fast, 11 precharge
// RQ4 - On output undervoltage, capture power-path bit, then restore its default
// RQ5 - In undervoltage with input present, the latch drives charger and path
// RQ6 - Latch returns high only when input power is removed
// RQ7 - Leaving undervoltage, the register bit again drives charger and path
// RQ8 - Supplement status bit is always masked and never raises an event
// RQ9 - AC and USB detect bits mean something only with regulator in range
// RQ10 - Supplement set above about 60 mV, cleared below 20 mV
// RQ11 - Select bit: set 4.2 V, clear 4.36 V; safety bit must permit 4.36 V
// RQ12 - Suspend, USB limit, input limit and power source bits steer outputs
package charger_regs_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [7:0] ADDR_CHARGER_CONFIG = 8'h09;
    localparam logic [7:0] ADDR_PORT3_SAFETY = 8'h1C;
    localparam logic [7:0] ADDR_CHARGER_STATUS = 8'h0A;

    // ==========================================================
    // Reset values
    localparam logic [7:0] CONFIG_RESET = 8'hD9;
    localparam logic [7:0] PORT3_RESET = 8'h00;
    localparam logic CE_DEFAULT = 1'b1;
    localparam logic LATCH_POWERUP = 1'b1;

    // ==========================================================
    // Field positions
    localparam int CFG_CE_BIT = 0;
    localparam int PORT3_SAFETY_BIT = 4;

    // ==========================================================
    // Charge state codes
    localparam logic [1:0] STATE_FAULT_OFF = 2'h0;
    localparam logic [1:0] STATE_DONE = 2'h1;
    localparam logic [1:0] STATE_FAST = 2'h2;
    localparam logic [1:0] STATE_PRECHARGE = 2'h3;

    // ==========================================================
    // Bus constants
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef struct packed {
        logic chargeVoltageSelect;
        logic chargeRunBit;
        logic unused;
        logic currentScaleHigh;
        logic currentScaleLow;
        logic usbCurrentLimitSelect;
        logic inputLimitMax;
        logic powerPathEnable;
    } config_t;

    typedef struct packed {
        logic supplementMode;
        logic selectedInputFlag;
        logic thermalOrPowerLoopActive;
        logic acInputPresent;
        logic usbInputPresent;
        logic chargeStateCodeHigh;
        logic chargeStateCodeLow;
        logic inputOvervoltageFlag;
    } status_t;

    // Raw analog comparator and charger-core levels
    typedef struct packed {
        logic acDetect;
        logic usbDetect;
        logic regulatorGood;
        logic usbSelected;
        logic loopActive;
        logic overvoltage;
        logic supplementEnter;
        logic supplementExit;
        logic outUndervoltage;
        logic fastChargeOn;
        logic prechargeOn;
        logic chargeDone;
        logic faultActive;
    } analog_t;

    typedef struct packed {
        logic chargeEnable;
        logic powerFromInput;
        logic select436;
        logic usbLimit500;
        logic inputLimitMax;
        logic [1:0] currentScale;
    } drive_t;

endpackage

// ---- logic/charger_control_status_regs.sv ----
// I2C-reached charger configuration and status registers with CE latch
`timescale 1ns/100ps
module charger_control_status_regs
    import charger_regs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic statusChange,
    input wire logic chargerClk,
    input analog_t analogIn,
    output drive_t chargerDrive,
    output logic statusValid
);

    // ==========================================================
    // Parameter check
    generate
        if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_bad
            $error("DEV_ADDR lies in a reserved I2C address range");
        end
    endgenerate

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_PTR = 9'h008,
        ST_PTR_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RDATA_ACK = 9'h100
    } bus_state_t;

    // ==========================================================
    // Bus pin synchronisers and edge detect
    logic [1:0] sclSync_reg;
    logic [1:0] sdaSync_reg;
    logic sclPrev_reg;
    logic sdaPrev_reg;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;

    always_ff @(posedge clk) begin
        if (reset) begin
            sclSync_reg <= 2'h3;
            sdaSync_reg <= 2'h3;
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            sclSync_reg <= {sclSync_reg[0], scl};
            sdaSync_reg <= {sdaSync_reg[0], sdaIn};
            sclPrev_reg <= sclSync_reg[1];
            sdaPrev_reg <= sdaSync_reg[1];
        end
    end

    assign sclRise = sclSync_reg[1] && !sclPrev_reg;
    assign sclFall = !sclSync_reg[1] && sclPrev_reg;
    assign startSeen = sclSync_reg[1] && sclPrev_reg &&
        sdaPrev_reg && !sdaSync_reg[1];
    assign stopSeen = sclSync_reg[1] && sclPrev_reg &&
        !sdaPrev_reg && sdaSync_reg[1];

    // ==========================================================
    // Registers and crossings
    logic [7:0] config_reg;
    logic [7:0] port3_reg;
    logic [7:0] pointer_reg;
    status_t statusSync1_reg;
    status_t statusSync2_reg;
    status_t statusPrev_reg;
    status_t statusOut_reg;
    logic ceEvtToggle_reg;
    logic [2:0] ceEvtSync_reg;
    logic ceRestore;
    logic writeStrobe;
    logic [7:0] writeData;
    logic [7:0] readData;

    assign ceRestore = ceEvtSync_reg[2] ^ ceEvtSync_reg[1];

    always_comb begin
        case (pointer_reg)
            ADDR_CHARGER_CONFIG: readData = config_reg;
            ADDR_PORT3_SAFETY: readData = port3_reg;
            ADDR_CHARGER_STATUS: readData = statusSync2_reg; // [RQ1]
            default: readData = READ_UNMAPPED;
        endcase
    end

    // Undervoltage restore outranks a host write in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            config_reg <= CONFIG_RESET;
        end else if (ceRestore) begin
            config_reg[CFG_CE_BIT] <= CE_DEFAULT; // [RQ4]
        end else if (writeStrobe && pointer_reg == ADDR_CHARGER_CONFIG) begin
            config_reg <= writeData; // [RQ12]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            port3_reg <= PORT3_RESET;
        end else if (writeStrobe && pointer_reg == ADDR_PORT3_SAFETY) begin
            port3_reg <= writeData;
        end
    end

    // Per-bit level crossing; each status bit is an independent level
    always_ff @(posedge clk) begin
        if (reset) begin
            statusSync1_reg <= '0;
            statusSync2_reg <= '0;
            statusPrev_reg <= '0;
            ceEvtSync_reg <= 3'h0;
            statusChange <= 1'b0;
        end else begin
            statusSync1_reg <= statusOut_reg;
            statusSync2_reg <= statusSync1_reg;
            statusPrev_reg <= statusSync2_reg;
            ceEvtSync_reg <= {ceEvtSync_reg[1:0], ceEvtToggle_reg};
            statusChange <= (statusSync2_reg[6:0] != statusPrev_reg[6:0]); // [RQ8]
        end
    end

    // ==========================================================
    // I2C slave
    bus_state_t state_reg;
    logic [2:0] bitCnt_reg;
    logic [7:0] rxShift_reg;
    logic [7:0] txShift_reg;
    logic readMode_reg;
    logic ackPhase_reg;
    logic masterNack_reg;
    logic [7:0] rxNext;

    assign rxNext = {rxShift_reg[6:0], sdaSync_reg[1]};
    assign writeStrobe = (state_reg == ST_WDATA) && sclRise &&
        (bitCnt_reg == LAST_BIT);
    assign writeData = rxNext;

    always_ff @(posedge clk) begin
        if (reset) begin
            sdaOut <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || stopSeen) begin
            state_reg <= ST_IDLE;
            bitCnt_reg <= 3'h0;
            rxShift_reg <= 8'h00;
            txShift_reg <= 8'h00;
            readMode_reg <= 1'b0;
            ackPhase_reg <= 1'b0;
            masterNack_reg <= 1'b0;
            sdaOe <= 1'b0;
            pointer_reg <= 8'h00;
        end else if (startSeen) begin
            state_reg <= ST_ADDR;
            bitCnt_reg <= 3'h0;
            sdaOe <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    sdaOe <= 1'b0;
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (sclRise) begin
                        rxShift_reg <= rxNext;
                        bitCnt_reg <= bitCnt_reg + 3'h1;
                        ackPhase_reg <= 1'b0;
                        if (bitCnt_reg == LAST_BIT) begin
                            if (state_reg == ST_ADDR) begin
                                readMode_reg <= rxNext[0];
                                state_reg <= (rxNext[7:1] == DEV_ADDR) ?
                                    ST_ADDR_ACK : ST_IDLE;
                            end else if (state_reg == ST_PTR) begin
                                pointer_reg <= rxNext;
                                state_reg <= ST_PTR_ACK;
                            end else begin
                                state_reg <= ST_WDATA_ACK;
                            end
                        end
                    end
                end
                ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
                    if (sclFall && !ackPhase_reg) begin
                        sdaOe <= 1'b1;
                        ackPhase_reg <= 1'b1;
                    end else if (sclFall) begin
                        bitCnt_reg <= 3'h0;
                        if (state_reg == ST_ADDR_ACK && readMode_reg) begin
                            txShift_reg <= readData;
                            sdaOe <= !readData[7];
                            state_reg <= ST_RDATA;
                        end else begin
                            sdaOe <= 1'b0;
                            state_reg <= (state_reg == ST_ADDR_ACK) ?
                                ST_PTR : ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclRise) begin
                        bitCnt_reg <= bitCnt_reg + 3'h1;
                        ackPhase_reg <= 1'b0;
                        if (bitCnt_reg == LAST_BIT) begin
                            state_reg <= ST_RDATA_ACK;
                        end
                    end else if (sclFall) begin
                        txShift_reg <= {txShift_reg[6:0], 1'b0};
                        sdaOe <= !txShift_reg[6];
                    end
                end
                ST_RDATA_ACK: begin
                    if (sclFall && !ackPhase_reg) begin
                        sdaOe <= 1'b0;
                    end else if (sclRise) begin
                        ackPhase_reg <= 1'b1;
                        masterNack_reg <= sdaSync_reg[1];
                    end else if (sclFall) begin
                        bitCnt_reg <= 3'h0;
                        if (masterNack_reg) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            txShift_reg <= readData;
                            sdaOe <= !readData[7];
                            state_reg <= ST_RDATA;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    sdaOe <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Charger clock domain
    logic [1:0] chgRst_reg;
    logic chgReset;
    config_t cfgSync1_reg;
    config_t cfgSync2_reg;
    logic [1:0] safetySync_reg;
    analog_t anaSync1_reg;
    analog_t anaSync2_reg;
    logic uvloPrev_reg;
    logic ceLatch_reg;
    logic supplement_reg;
    logic inputPresent;
    logic ceEffective;
    logic [1:0] stateCode;

    assign chgReset = chgRst_reg[1];
    assign inputPresent = anaSync2_reg.acDetect || anaSync2_reg.usbDetect;
    // Latch governs only inside undervoltage with a supply attached
    assign ceEffective = (anaSync2_reg.outUndervoltage && inputPresent) ?
        ceLatch_reg : cfgSync2_reg.powerPathEnable; // [RQ5] [RQ7]

    always_comb begin
        if (!inputPresent || anaSync2_reg.faultActive ||
            !cfgSync2_reg.chargeRunBit) begin
            stateCode = STATE_FAULT_OFF; // [RQ3]
        end else if (anaSync2_reg.prechargeOn) begin
            stateCode = STATE_PRECHARGE; // [RQ3]
        end else if (anaSync2_reg.fastChargeOn) begin
            stateCode = STATE_FAST; // [RQ3]
        end else if (anaSync2_reg.chargeDone) begin
            stateCode = STATE_DONE; // [RQ3]
        end else begin
            stateCode = STATE_FAULT_OFF;
        end
    end

    always_ff @(posedge chargerClk) begin
        chgRst_reg <= {chgRst_reg[0], reset};
    end

    always_ff @(posedge chargerClk) begin
        if (chgReset) begin
            cfgSync1_reg <= CONFIG_RESET;
            cfgSync2_reg <= CONFIG_RESET;
            safetySync_reg <= 2'h0;
            anaSync1_reg <= '0;
            anaSync2_reg <= '0;
        end else begin
            cfgSync1_reg <= config_reg;
            cfgSync2_reg <= cfgSync1_reg;
            safetySync_reg <= {safetySync_reg[0],
                port3_reg[PORT3_SAFETY_BIT]};
            anaSync1_reg <= analogIn;
            anaSync2_reg <= anaSync1_reg;
        end
    end

    // Capture and signal the bus side in the same cycle; the register restore follows later
    always_ff @(posedge chargerClk) begin
        if (chgReset) begin
            uvloPrev_reg <= 1'b0;
            ceLatch_reg <= LATCH_POWERUP;
            ceEvtToggle_reg <= 1'b0;
        end else begin
            uvloPrev_reg <= anaSync2_reg.outUndervoltage;
            if (!inputPresent) begin
                ceLatch_reg <= LATCH_POWERUP; // [RQ6]
            end else if (anaSync2_reg.outUndervoltage && !uvloPrev_reg) begin
                ceLatch_reg <= cfgSync2_reg.powerPathEnable; // [RQ4]
            end
            if (anaSync2_reg.outUndervoltage && !uvloPrev_reg) begin
                ceEvtToggle_reg <= !ceEvtToggle_reg; // [RQ4]
            end
        end
    end

    // Comparator pair gives the hysteresis band
    always_ff @(posedge chargerClk) begin
        if (chgReset) begin
            supplement_reg <= 1'b0;
        end else if (anaSync2_reg.supplementEnter) begin
            supplement_reg <= 1'b1; // [RQ10]
        end else if (anaSync2_reg.supplementExit) begin
            supplement_reg <= 1'b0; // [RQ10]
        end
    end

    always_ff @(posedge chargerClk) begin
        if (chgReset) begin
            statusOut_reg <= '0;
            statusValid <= 1'b0;
        end else begin
            statusValid <= inputPresent; // [RQ1]
            statusOut_reg.supplementMode <= supplement_reg;
            statusOut_reg.selectedInputFlag <= anaSync2_reg.usbSelected;
            statusOut_reg.thermalOrPowerLoopActive <= anaSync2_reg.loopActive;
            statusOut_reg.acInputPresent <= anaSync2_reg.acDetect &&
                anaSync2_reg.regulatorGood; // [RQ9]
            statusOut_reg.usbInputPresent <= anaSync2_reg.usbDetect &&
                anaSync2_reg.regulatorGood; // [RQ9]
            statusOut_reg.chargeStateCodeHigh <= stateCode[1];
            statusOut_reg.chargeStateCodeLow <= stateCode[0];
            statusOut_reg.inputOvervoltageFlag <= anaSync2_reg.overvoltage;
        end
    end

    always_ff @(posedge chargerClk) begin
        if (chgReset) begin
            chargerDrive <= '0;
        end else begin
            chargerDrive.chargeEnable <= cfgSync2_reg.chargeRunBit &&
                ceEffective && inputPresent; // [RQ12]
            chargerDrive.powerFromInput <= ceEffective; // [RQ12]
            chargerDrive.select436 <= !cfgSync2_reg.chargeVoltageSelect &&
                safetySync_reg[1]; // [RQ11]
            chargerDrive.usbLimit500 <=
                cfgSync2_reg.usbCurrentLimitSelect; // [RQ12]
            chargerDrive.inputLimitMax <= cfgSync2_reg.inputLimitMax;
            chargerDrive.currentScale <= {cfgSync2_reg.currentScaleHigh,
                cfgSync2_reg.currentScaleLow}; // [RQ2]
        end
    end

endmodule

// ---- tb/charger_regs_monitor.sv ----
// Port checker for the charger register bank, bound to its top module
`timescale 1ns/100ps
module charger_regs_monitor
    import charger_regs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sdaIn,
    input logic sdaOut,
    input logic sdaOe,
    input logic statusChange,
    input wire logic chargerClk,
    input analog_t analogIn,
    input drive_t chargerDrive,
    input logic statusValid
);
    // ==========================================================
    // Run-length counters: long holds outlast the synchronisers
    logic present;
    logic uvNoInput;
    logic [3:0] inCnt;
    logic [3:0] outCnt;
    logic [4:0] uvCnt;
    assign present = analogIn.acDetect | analogIn.usbDetect;
    assign uvNoInput = analogIn.outUndervoltage & !present;
    always_ff @(posedge chargerClk) begin
        if (reset || !present) inCnt <= 4'h0;
        else if (inCnt != 4'hF) inCnt <= inCnt + 4'h1;
    end
    always_ff @(posedge chargerClk) begin
        if (reset || present) outCnt <= 4'h0;
        else if (outCnt != 4'hF) outCnt <= outCnt + 4'h1;
    end
    always_ff @(posedge chargerClk) begin
        if (reset || !uvNoInput) uvCnt <= 5'h00;
        else if (uvCnt != 5'h1F) uvCnt <= uvCnt + 5'h01;
    end
    // ==========================================================
    // Bus side
    sda_low_a: assert property (@(posedge clk) disable iff (reset)
        sdaOut == 1'b0) else $error("sdaOut not low");
    oe_scl_low_a: assert property (@(posedge clk) disable iff (reset)
        $changed(sdaOe) |-> !scl && !$past(scl))
        else $error("sdaOe moved while scl high");
    reset_quiet_a: assert property (@(posedge clk)
        reset |=> !sdaOe && !statusChange)
        else $error("outputs active in reset");
    // ==========================================================
    // Charger side
    in_valid_a: assert property (@(posedge chargerClk)
        disable iff (reset) inCnt == 4'hF |-> statusValid)
        else $error("statusValid low with input");
    out_invalid_a: assert property (@(posedge chargerClk)
        disable iff (reset) outCnt == 4'hF |-> !statusValid)
        else $error("statusValid high without input");
    ce_present_a: assert property (@(posedge chargerClk)
        disable iff (reset) chargerDrive.chargeEnable |->
        $past(present, 2) || $past(present, 3) || $past(present, 4) ||
        $past(present, 5)) else $error("charging without input");
    ce_path_a: assert property (@(posedge chargerClk)
        disable iff (reset)
        chargerDrive.chargeEnable |-> chargerDrive.powerFromInput)
        else $error("charge enabled with battery path");
    latch_hold_a: assert property (@(posedge chargerClk)
        disable iff (reset)
        (analogIn.outUndervoltage && present)[*8] ##1
        (analogIn.outUndervoltage && present)
        |-> $stable(chargerDrive.powerFromInput))
        else $error("path moved while latch rules");
    uv_default_a: assert property (@(posedge chargerClk)
        disable iff (reset) uvCnt == 5'h1F |-> chargerDrive.powerFromInput)
        else $error("path not at default after input loss");
endmodule

bind charger_control_status_regs charger_regs_monitor mon_u (
    .clk(clk), .reset(reset), .scl(scl), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .statusChange(statusChange),
    .chargerClk(chargerClk), .analogIn(analogIn),
    .chargerDrive(chargerDrive), .statusValid(statusValid));

// ---- tb/i2c_host_model.sv ----
// Behavioural I2C host reaching the charger register bank
`timescale 1ns/100ps
module i2c_host_model #(
    parameter logic [6:0] DEV = 7'h2A // Arbitrary bus address
) (
    input wire logic clk,
    input wire logic sdaOe,
    output logic scl,
    output logic sdaIn
);
    // ==========================================================
    // Open-drain line with pull-up; phases of 5 clk keep 250 ns
    localparam int HALF = 5;
    logic hostLow = 1'b0;
    initial scl = 1'b1;
    assign sdaIn = !(hostLow || sdaOe);
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic start();
        tick(1);
        hostLow = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        hostLow = 1'b1;
        tick(HALF);
        scl = 1'b0;
    endtask
    task automatic stop();
        tick(1);
        hostLow = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        hostLow = 1'b0;
        tick(HALF);
    endtask
    // Data moves one clk after SCL falls, never beside it
    task automatic bitx(input logic b, output logic got);
        tick(1);
        hostLow = !b;
        tick(HALF);
        scl = 1'b1;
        got = sdaIn;
        tick(HALF);
        scl = 1'b0;
    endtask
    task automatic byteX(input logic [7:0] tx, input logic ackTx,
                         output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
        bitx(ackTx, ack);
    endtask
    task automatic writeReg(input logic [7:0] ptr, input logic [7:0] d,
                            output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start();
        byteX({DEV, 1'b0}, 1'b1, rx, a0);
        byteX(ptr, 1'b1, rx, a1);
        byteX(d, 1'b1, rx, a2);
        stop();
        ok = !(a0 || a1 || a2);
    endtask
    task automatic readReg(input logic [7:0] ptr, output logic [7:0] d);
        logic [7:0] rx;
        logic a;
        start();
        byteX({DEV, 1'b0}, 1'b1, rx, a);
        byteX(ptr, 1'b1, rx, a);
        start();
        byteX({DEV, 1'b1}, 1'b1, rx, a);
        byteX(8'hFF, 1'b1, d, a);
        stop();
    endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking testbench for the charger register bank
`timescale 1ns/100ps
module tb
    import charger_regs_pkg::*;
;
    logic clk, reset, chargerClk, scl, sdaIn, sdaOut, sdaOe;
    logic statusChange, statusValid;
    analog_t ana;
    drive_t drv;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0, pulses = 0;
    logic [7:0] v;
    logic ok;

    charger_control_status_regs dut_u (.clk(clk), .reset(reset),
        .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .statusChange(statusChange), .chargerClk(chargerClk),
        .analogIn(ana), .chargerDrive(drv), .statusValid(statusValid));
    i2c_host_model host_u (.clk(clk), .sdaOe(sdaOe), .scl(scl),
        .sdaIn(sdaIn));

    // ==========================================================
    // Clocks, timeout, event counter
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        chargerClk = 1'b0;
        #7;
        forever #15 chargerClk = ~chargerClk;
    end
    always @(posedge clk) begin
        cycles++;
        if (statusChange === 1'b1) pulses++;
        if (cycles == 60000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] exp);
        host_u.readReg(p, v);
        check8(v, exp);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        host_u.writeReg(p, d, ok);
        check8({7'h00, ok}, 8'h01);
    endtask
    task automatic settle();
        repeat (16) @(posedge chargerClk);
        @(negedge clk);
    endtask
    task automatic srd(input logic [7:0] e);
        settle();
        rd(ADDR_CHARGER_STATUS, e);
    endtask
    task automatic wdrv(input logic [7:0] p, d, e);
        wr(p, d);
        settle();
        check8({1'b0, drv}, e);
    endtask
    task automatic pfi(input logic e);
        check8({7'h00, drv.powerFromInput}, {7'h00, e});
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_fields();
        rd(ADDR_CHARGER_CONFIG, CONFIG_RESET);
        rd(ADDR_PORT3_SAFETY, PORT3_RESET);
        check8({1'b0, drv}, 8'h63);
        for (int s = 0; s < 4; s++) begin
            wdrv(ADDR_CHARGER_CONFIG, 8'h47 | 8'(s << 3),
                8'h6C | 8'(s));
        end
        wdrv(ADDR_PORT3_SAFETY, 8'h10, 8'h7F);
        wdrv(ADDR_CHARGER_CONFIG, 8'h9F, 8'h2F);
        wdrv(ADDR_CHARGER_CONFIG, 8'h59, 8'h73);
        wdrv(ADDR_CHARGER_CONFIG, 8'h58, 8'h13);
        rd(ADDR_PORT3_SAFETY, 8'h10);
        wr(8'h30, 8'h55);
        rd(8'h30, READ_UNMAPPED);
        wr(ADDR_CHARGER_CONFIG, CONFIG_RESET);
        host_u.start();
        host_u.byteX({7'h2B, 1'b0}, 1'b1, v, ok);
        host_u.stop();
        check8({7'h00, ok}, 8'h01);
    endtask

    task automatic test_status();
        logic [1:0] codes [4];
        codes = '{STATE_FAULT_OFF, STATE_DONE, STATE_FAST, STATE_PRECHARGE};
        for (int i = 0; i < 4; i++) begin
            ana.faultActive = (i == 0);
            ana.chargeDone = (i == 1);
            ana.fastChargeOn = (i == 2);
            ana.prechargeOn = (i == 3);
            srd(8'h10 | {5'h00, codes[i], 1'b0});
        end
        wr(ADDR_CHARGER_STATUS, 8'h00);
        rd(ADDR_CHARGER_STATUS, 8'h16);
        ana.usbDetect = 1'b1;
        ana.usbSelected = 1'b1;
        ana.loopActive = 1'b1;
        ana.overvoltage = 1'b1;
        srd(8'h7F);
        check8({7'h00, statusValid}, 8'h01);
        ana.regulatorGood = 1'b0;
        srd(8'h67);
        ana = '0;
        settle();
        check8({7'h00, statusValid}, 8'h00);
        check8({7'h00, drv.chargeEnable}, 8'h00);
        ana.acDetect = 1'b1;
        ana.regulatorGood = 1'b1;
        settle();
    endtask

    task automatic test_supplement();
        pulses = 0;
        ana.supplementEnter = 1'b1;
        srd(8'h90);
        ana.supplementEnter = 1'b0;
        srd(8'h90);
        ana.supplementExit = 1'b1;
        srd(8'h10);
        ana.supplementExit = 1'b0;
        check8(8'(pulses), 8'h00);
        ana.overvoltage = 1'b1;
        settle();
        ana.overvoltage = 1'b0;
        settle();
        check8(8'(pulses), 8'h02);
    endtask

    task automatic test_uvlo();
        wr(ADDR_CHARGER_CONFIG, 8'hD8);
        ana.outUndervoltage = 1'b1;
        settle();
        settle();
        rd(ADDR_CHARGER_CONFIG, CONFIG_RESET);
        pfi(1'b0);
        ana.outUndervoltage = 1'b0;
        settle();
        pfi(1'b1);
        wr(ADDR_CHARGER_CONFIG, 8'hD8);
        ana.outUndervoltage = 1'b1;
        settle();
        settle();
        ana.acDetect = 1'b0;
        settle();
        ana.acDetect = 1'b1;
        settle();
        wr(ADDR_CHARGER_CONFIG, 8'hD8);
        settle();
        pfi(1'b1);
        ana.outUndervoltage = 1'b0;
        settle();
        pfi(1'b0);
        wr(ADDR_CHARGER_CONFIG, CONFIG_RESET);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        reset = 1'b1;
        ana = '0;
        ana.acDetect = 1'b1;
        ana.regulatorGood = 1'b1;
        repeat (12) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        settle();
        test_fields();
        test_status();
        test_supplement();
        test_uvlo();
        report_and_stop();
    end
endmodule
